// ---- logic/pll_chain_pkg.sv ----
package pll_chain_pkg;

    // ************************************************************
    // sizes and field widths
    // ************************************************************
    localparam int N_APLL = 3;
    localparam int N_REF = 2;
    localparam int N_CHAN = 16;
    localparam int N_POST = 5;
    localparam int APLL_INT_W = 12;
    localparam int APLL_NUM_W = 40;
    localparam int APLL_DEN_W = 24;
    localparam int DPLL_INT_W = 33;
    localparam int DPLL_NUM_W = 40;
    localparam int DPLL_DEN_W = 40;
    localparam int CH_DIV_W = 12;
    localparam int SYSREF_W = 20;
    localparam int REF_DIV_W = 16;
    localparam int XO_R_W = 5;
    localparam int POST_W = 4;
    localparam int TDC_W = 16;
    localparam int CASC_W = 4;
    localparam int CAL_CNT_W = 8;

    // ************************************************************
    // denominators
    // ************************************************************
    localparam logic [40:0] DEN_FIXED = 41'h100_0000_0000;
    localparam logic [40:0] DEN24_FULL = 41'h000_0100_0000;

    // ************************************************************
    // post-dividers: A1 primary, A1 secondary, A2 primary,
    // A2 secondary, A3
    // ************************************************************
    localparam logic [POST_W-1:0] POST_MIN [N_POST] =
        '{4'h2, 4'h2, 4'h2, 4'h2, 4'h1};
    localparam logic [POST_W-1:0] POST_MAX [N_POST] =
        '{4'h7, 4'h7, 4'hD, 4'h3, 4'h7};
    localparam int POST_VCO [N_POST] = '{0, 0, 1, 1, 2};
    localparam logic [N_CHAN-1:0] ROUTE_MASK [N_POST] =
        '{16'hC00F, 16'h000F, 16'hFFFF, 16'h0050, 16'hFFF3};
    localparam logic [N_CHAN-1:0] SYSREF_MASK = 16'h3FF3;
    localparam logic [CASC_W-1:0] CASCADE_DIV = 4'h2;
    localparam logic [1:0] REF_XO = 2'h0;

    // ************************************************************
    // calibration timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYCLES =
        (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SRC_A1_PRI = 3'h0,
        SRC_A1_SEC = 3'h1,
        SRC_A2_PRI = 3'h2,
        SRC_A2_SEC = 3'h3,
        SRC_A3 = 3'h4,
        SRC_OFF = 3'h7
    } chan_src_e;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'h0,
        CAL_WAIT_XO = 3'h1,
        CAL_RUN = 3'h3,
        CAL_LOCK = 3'h2,
        CAL_DONE = 3'h6
    } cal_state_e;

endpackage: pll_chain_pkg

// ---- logic/div_if.sv ----
interface div_if #(parameter int W = 4);
    logic tick_in;
    logic [W-1:0] div_value;
    logic tick_out;
    modport ctrl(output tick_in, output div_value, input tick_out);
    modport core(input tick_in, input div_value, output tick_out);
endinterface: div_if

// ---- logic/tick_divider.sv ----
module tick_divider #(parameter int W = 4) (
    input wire logic core_clk,
    input wire logic sys_rst,
    div_if.core dv
);
    logic [W-1:0] cnt_r, cnt_nxt, val_r, val_nxt;
    logic out_r, out_nxt, last;

    assign last = (val_r <= W'(1)) || (cnt_r >= val_r - W'(1));
    assign dv.tick_out = out_r;

    always_comb begin
        cnt_nxt = cnt_r;
        val_nxt = val_r;
        out_nxt = 1'b0;
        if (dv.tick_in) begin
            if (last) begin
                cnt_nxt = '0;
                out_nxt = 1'b1;
                val_nxt = dv.div_value;
            end else begin
                cnt_nxt = cnt_r + W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
            val_r <= W'(1);
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            val_r <= val_nxt;
            out_r <= out_nxt;
        end
    end

    a_div_value_hold: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !out_r |-> $stable(val_r))
        else $error("divide value changed inside a period");
    a_div_mid_period: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (dv.tick_in && !last) |=> !out_r && cnt_r != '0)
        else $error("divider ticked before period end");
endmodule: tick_divider

// ---- logic/pll_divider_chain_control.sv ----
module pll_divider_chain_control (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic xo_rise_tick,
    input wire logic xo_fall_tick,
    input wire logic xo_loss,
    input wire logic xo_doubler_en,
    input wire logic ref_in_tick [2],
    input wire logic [15:0] ref_div_value [2],
    input wire logic vco_tick [3],
    input wire logic [4:0] xo_r_div [3],
    input wire logic [1:0] apll_ref_src [3],
    input wire logic [3:0] post_div_value [5],
    input wire logic [11:0] apll_int [3],
    input wire logic [39:0] apll_num [3],
    input wire logic [23:0] apll_den [3],
    input wire logic apll_den_fixed [3],
    input wire logic dpll_mode [3],
    input wire logic [39:0] dlf_num [3],
    input wire logic dpll_ref_sel [3],
    input wire logic reference_feedback_value_select [3][2],
    input wire logic [32:0] dpll_fb_int [3][2],
    input wire logic [39:0] dpll_fb_num [3][2],
    input wire logic [39:0] dpll_fb_den [3][2],
    input wire logic analog_loop_enable_bit [3],
    input wire logic apll_locked [3],
    input wire pll_chain_pkg::chan_src_e chan_src_sel [16],
    input wire logic [11:0] output_channel_divider [16],
    input wire logic sysref_en [16],
    input wire logic [19:0] sysref_div [16],
    input wire logic mute_until_lock [16],
    output logic clock_output_channel [16],
    output logic post_div_tick [5],
    output logic pd_ref_tick [3],
    output logic [12:0] apll_n_word [3],
    output logic fb_clk_tick [3],
    output logic [15:0] tdc_err [3],
    output logic tdc_valid [3],
    output logic cal_busy [3],
    output logic cal_done [3]
);
    logic [15:0] stamp_r, stamp_nxt;
    logic ref_div_tick [2];
    logic casc_tick [3];
    logic post_tick [5];
    logic xo_pd_tick;

    // ************************************************************
    // time base for the phase converter
    // ************************************************************
    assign stamp_nxt = stamp_r + 16'h0001;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stamp_r <= 16'h0000;
        end else begin
            stamp_r <= stamp_nxt;
        end
    end

    // ************************************************************
    // reference dividers and crystal doubler
    // ************************************************************
    assign xo_pd_tick = xo_rise_tick || (xo_doubler_en && xo_fall_tick);

    for (genvar r = 0; r < pll_chain_pkg::N_REF; r++) begin : g_ref
        div_if #(.W(pll_chain_pkg::REF_DIV_W)) rdv();
        assign rdv.tick_in = ref_in_tick[r];
        assign rdv.div_value = ref_div_value[r];
        assign ref_div_tick[r] = rdv.tick_out;
        tick_divider #(.W(pll_chain_pkg::REF_DIV_W)) u_div (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(rdv));
    end

    // ************************************************************
    // analog loops: reference path, modulator, calibration
    // ************************************************************
    for (genvar a = 0; a < pll_chain_pkg::N_APLL; a++) begin : g_apll
        logic ref_tick;
        logic [39:0] num_app;
        logic [40:0] den_app, sdm_sum, sdm_acc_r, sdm_acc_nxt;
        logic [12:0] n_word_r, n_word_nxt;
        pll_chain_pkg::cal_state_e st_r, st_nxt;
        logic [7:0] cal_cnt_r, cal_cnt_nxt;
        logic en_d_r, en_rise;

        div_if #(.W(pll_chain_pkg::CASC_W)) cdv();
        assign cdv.tick_in = vco_tick[a];
        assign cdv.div_value = pll_chain_pkg::CASCADE_DIV;
        assign casc_tick[a] = cdv.tick_out;
        tick_divider #(.W(pll_chain_pkg::CASC_W)) u_casc (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(cdv));

        assign ref_tick = (apll_ref_src[a] == pll_chain_pkg::REF_XO) ?
            xo_pd_tick : casc_tick[apll_ref_src[a] - 2'h1];

        div_if #(.W(6)) xdv();
        assign xdv.tick_in = ref_tick;
        assign xdv.div_value = {1'b0, xo_r_div[a]} + 6'h01;
        assign pd_ref_tick[a] = xdv.tick_out;
        tick_divider #(.W(6)) u_xo_r (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(xdv));

        // first-order modulator stepping once per phase detector tick
        always_comb begin
            num_app = dpll_mode[a] ? dlf_num[a] : apll_num[a];
            if (apll_den_fixed[a]) begin
                den_app = pll_chain_pkg::DEN_FIXED;
            end else if (apll_den[a] == 24'h000000) begin
                den_app = pll_chain_pkg::DEN24_FULL;
            end else begin
                den_app = {17'h00000, apll_den[a]};
            end
            sdm_sum = sdm_acc_r + {1'b0, num_app};
            sdm_acc_nxt = sdm_acc_r;
            n_word_nxt = n_word_r;
            if (pd_ref_tick[a]) begin
                if (sdm_sum >= den_app) begin
                    sdm_acc_nxt = sdm_sum - den_app;
                    n_word_nxt = {1'b0, apll_int[a]} + 13'h0001;
                end else begin
                    sdm_acc_nxt = sdm_sum;
                    n_word_nxt = {1'b0, apll_int[a]};
                end
            end
        end

        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                sdm_acc_r <= 41'h000_0000_0000;
                n_word_r <= 13'h0000;
            end else begin
                sdm_acc_r <= sdm_acc_nxt;
                n_word_r <= n_word_nxt;
            end
        end
        assign apll_n_word[a] = n_word_r;

        a_sdm_loop_drive: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (pd_ref_tick[a] && dpll_mode[a] && dlf_num[a] == 40'h0
             && sdm_acc_r < den_app) |=> $stable(sdm_acc_r))
            else $error("modulator not driven by loop word");

        assign en_rise = analog_loop_enable_bit[a] && !en_d_r;

        always_comb begin
            st_nxt = st_r;
            cal_cnt_nxt = cal_cnt_r;
            unique case (st_r)
                pll_chain_pkg::CAL_IDLE: begin
                    st_nxt = pll_chain_pkg::CAL_WAIT_XO;
                end
                pll_chain_pkg::CAL_WAIT_XO: begin
                    if (!xo_loss) begin
                        st_nxt = pll_chain_pkg::CAL_RUN;
                        cal_cnt_nxt = 8'h00;
                    end
                end
                pll_chain_pkg::CAL_RUN: begin
                    if (cal_cnt_r == 8'(pll_chain_pkg::CAL_CYCLES - 1)) begin
                        st_nxt = pll_chain_pkg::CAL_LOCK;
                    end else begin
                        cal_cnt_nxt = cal_cnt_r + 8'h01;
                    end
                end
                pll_chain_pkg::CAL_LOCK: begin
                    if (apll_locked[a]) begin
                        st_nxt = pll_chain_pkg::CAL_DONE;
                    end
                end
                pll_chain_pkg::CAL_DONE: begin
                    st_nxt = pll_chain_pkg::CAL_DONE;
                end
                default: begin
                    st_nxt = pll_chain_pkg::CAL_IDLE;
                end
            endcase
            if (!analog_loop_enable_bit[a]) begin
                st_nxt = pll_chain_pkg::CAL_IDLE;
            end else if (soft_rst || en_rise) begin
                st_nxt = pll_chain_pkg::CAL_WAIT_XO;
            end
        end

        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                st_r <= pll_chain_pkg::CAL_WAIT_XO;
                cal_cnt_r <= 8'h00;
                // enable's usual level, so no false rise follows reset
                en_d_r <= 1'b1;
            end else begin
                st_r <= st_nxt;
                cal_cnt_r <= cal_cnt_nxt;
                en_d_r <= analog_loop_enable_bit[a];
            end
        end
        assign cal_done[a] = (st_r == pll_chain_pkg::CAL_DONE);
        assign cal_busy[a] = (st_r != pll_chain_pkg::CAL_DONE) &&
            (st_r != pll_chain_pkg::CAL_IDLE);

        a_cal_holdoff: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (st_r == pll_chain_pkg::CAL_WAIT_XO && xo_loss)
            |=> st_r != pll_chain_pkg::CAL_RUN)
            else $error("calibration started during crystal loss");
        a_cal_restart: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            en_rise |=> st_r == pll_chain_pkg::CAL_WAIT_XO)
            else $error("enable rise did not restart calibration");
        a_cal_auto_start: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (st_r == pll_chain_pkg::CAL_WAIT_XO && !xo_loss && !soft_rst
             && !en_rise && analog_loop_enable_bit[a])
            |=> st_r == pll_chain_pkg::CAL_RUN ##1
                st_r == pll_chain_pkg::CAL_RUN)
            else $error("calibration did not start with crystal present");
    end

    // ************************************************************
    // digital loops: feedback divider and phase converter
    // ************************************************************
    for (genvar d = 0; d < pll_chain_pkg::N_APLL; d++) begin : g_dpll
        logic set_sel, fb_set_r, fb_set_nxt, fb_tick_r, fb_tick_nxt;
        logic [32:0] fb_cnt_r, fb_cnt_nxt, fb_tgt_r, fb_tgt_nxt;
        logic [40:0] fb_acc_r, fb_acc_nxt, fb_den, fb_sum;
        logic sel_ref_tick, armed_r, armed_nxt, valid_r, valid_nxt;
        logic [15:0] ref_ts_r, ref_ts_nxt, err_r, err_nxt;

        always_comb begin
            set_sel = reference_feedback_value_select[d][dpll_ref_sel[d]];
            fb_den = (dpll_fb_den[d][set_sel] == 40'h0) ?
                pll_chain_pkg::DEN_FIXED : {1'b0, dpll_fb_den[d][set_sel]};
            fb_sum = fb_acc_r + {1'b0, dpll_fb_num[d][set_sel]};
            fb_cnt_nxt = fb_cnt_r;
            fb_tgt_nxt = fb_tgt_r;
            fb_acc_nxt = fb_acc_r;
            fb_set_nxt = fb_set_r;
            fb_tick_nxt = 1'b0;
            if (vco_tick[d]) begin
                if (fb_cnt_r + 33'h1 >= fb_tgt_r) begin
                    fb_cnt_nxt = 33'h0;
                    fb_tick_nxt = 1'b1;
                    fb_set_nxt = set_sel;
                    if (fb_sum >= fb_den) begin
                        fb_acc_nxt = fb_sum - fb_den;
                        fb_tgt_nxt = dpll_fb_int[d][set_sel] + 33'h1;
                    end else begin
                        fb_acc_nxt = fb_sum;
                        fb_tgt_nxt = dpll_fb_int[d][set_sel];
                    end
                end else begin
                    fb_cnt_nxt = fb_cnt_r + 33'h1;
                end
            end
        end

        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                fb_cnt_r <= 33'h0;
                fb_tgt_r <= 33'h1;
                fb_acc_r <= 41'h000_0000_0000;
                fb_set_r <= 1'b0;
                fb_tick_r <= 1'b0;
            end else begin
                fb_cnt_r <= fb_cnt_nxt;
                fb_tgt_r <= fb_tgt_nxt;
                fb_acc_r <= fb_acc_nxt;
                fb_set_r <= fb_set_nxt;
                fb_tick_r <= fb_tick_nxt;
            end
        end
        assign fb_clk_tick[d] = fb_tick_r;

        a_fb_count_bound: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (fb_tgt_r != 33'h0) |-> fb_cnt_r < fb_tgt_r)
            else $error("feedback count passed its target");
        a_fb_set_hold: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            !fb_tick_r |-> $stable(fb_set_r))
            else $error("feedback set switched mid period");

        assign sel_ref_tick = ref_div_tick[dpll_ref_sel[d]];

        always_comb begin
            ref_ts_nxt = ref_ts_r;
            armed_nxt = armed_r;
            err_nxt = err_r;
            valid_nxt = 1'b0;
            if (fb_tick_r && (armed_r || sel_ref_tick)) begin
                err_nxt = sel_ref_tick ? 16'h0000 : stamp_r - ref_ts_r;
                valid_nxt = 1'b1;
                armed_nxt = 1'b0;
            end else if (sel_ref_tick) begin
                ref_ts_nxt = stamp_r;
                armed_nxt = 1'b1;
            end
        end

        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                ref_ts_r <= 16'h0000;
                armed_r <= 1'b0;
                err_r <= 16'h0000;
                valid_r <= 1'b0;
            end else begin
                ref_ts_r <= ref_ts_nxt;
                armed_r <= armed_nxt;
                err_r <= err_nxt;
                valid_r <= valid_nxt;
            end
        end
        assign tdc_err[d] = err_r;
        assign tdc_valid[d] = valid_r;

        a_tdc_same_edge: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (sel_ref_tick && fb_tick_r) |=> valid_r && err_r == 16'h0000)
            else $error("coincident edges gave nonzero error");
    end

    // ************************************************************
    // vco post-dividers
    // ************************************************************
    for (genvar p = 0; p < pll_chain_pkg::N_POST; p++) begin : g_post
        logic [3:0] pv;
        assign pv = (post_div_value[p] < pll_chain_pkg::POST_MIN[p]) ?
            pll_chain_pkg::POST_MIN[p] :
            (post_div_value[p] > pll_chain_pkg::POST_MAX[p]) ?
            pll_chain_pkg::POST_MAX[p] : post_div_value[p];
        div_if #(.W(pll_chain_pkg::POST_W)) pdv();
        assign pdv.tick_in = vco_tick[pll_chain_pkg::POST_VCO[p]];
        assign pdv.div_value = pv;
        assign post_tick[p] = pdv.tick_out;
        assign post_div_tick[p] = pdv.tick_out;
        tick_divider #(.W(pll_chain_pkg::POST_W)) u_div (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(pdv));

        a_post_range: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            pv >= pll_chain_pkg::POST_MIN[p] &&
            pv <= pll_chain_pkg::POST_MAX[p])
            else $error("post-divider value out of range");
    end

    // ************************************************************
    // output channels
    // ************************************************************
    for (genvar c = 0; c < pll_chain_pkg::N_CHAN; c++) begin : g_chan
        logic [2:0] s_idx;
        logic src_ok, use_sr, muted, cd_tick, sr_tick, out_r, out_nxt;
        assign s_idx = (chan_src_sel[c] <= pll_chain_pkg::SRC_A3) ?
            chan_src_sel[c] : 3'h0;
        assign src_ok = (chan_src_sel[c] <= pll_chain_pkg::SRC_A3) &&
            pll_chain_pkg::ROUTE_MASK[s_idx][c];
        assign use_sr = sysref_en[c] && pll_chain_pkg::SYSREF_MASK[c];
        assign muted = mute_until_lock[c] &&
            !(src_ok && cal_done[pll_chain_pkg::POST_VCO[s_idx]]);

        div_if #(.W(pll_chain_pkg::CH_DIV_W)) odv();
        assign odv.tick_in = src_ok && post_tick[s_idx];
        assign odv.div_value = output_channel_divider[c];
        assign cd_tick = odv.tick_out;
        tick_divider #(.W(pll_chain_pkg::CH_DIV_W)) u_od (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(odv));

        div_if #(.W(pll_chain_pkg::SYSREF_W)) sdv();
        assign sdv.tick_in = cd_tick && use_sr;
        assign sdv.div_value = sysref_div[c];
        assign sr_tick = sdv.tick_out;
        tick_divider #(.W(pll_chain_pkg::SYSREF_W)) u_sr (
            .core_clk(core_clk), .sys_rst(sys_rst), .dv(sdv));

        assign out_nxt = (use_sr ? sr_tick : cd_tick) && !muted;
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                out_r <= 1'b0;
            end else begin
                out_r <= out_nxt;
            end
        end
        assign clock_output_channel[c] = out_r;

        a_route_block: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (!src_ok)[*4] |-> !out_r)
            else $error("channel clocked from an unrouted source");
        a_mute_gate: assert property (
            @(posedge core_clk) disable iff (sys_rst)
            (mute_until_lock[c] && !cal_done[pll_chain_pkg::POST_VCO[s_idx]])
            |=> !out_r)
            else $error("muted channel produced a clock");
    end
endmodule: pll_divider_chain_control

// ---- tb/host_model.sv ----
module host_model (
    input wire logic core_clk,
    output logic analog_loop_enable_bit [3],
    output logic apll_den_fixed [3]
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        analog_loop_enable_bit = '{default: 1'b1};
        apll_den_fixed = '{default: 1'b1};
    end
    // enable cycle low then high restarts one loop
    task automatic recal(input int k);
        @(negedge core_clk);
        analog_loop_enable_bit[k] = 1'b0;
        repeat (2) @(negedge core_clk);
        analog_loop_enable_bit[k] = 1'b1;
    endtask: recal
endmodule: host_model

// ---- tb/pll_divider_chain_control_bench.sv ----
module pll_divider_chain_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, sys_rst = 1, soft_rst = 0, xo_loss = 1;
    logic xo_rise_tick = 0, xo_fall_tick = 0, xo_doubler_en = 0;
    logic ref_in_tick [2] = '{default: 0};
    logic [15:0] ref_div_value [2] = '{default: 0};
    logic vco_tick [3] = '{default: 1};
    logic [4:0] xo_r_div [3] = '{default: 0};
    logic [1:0] apll_ref_src [3] = '{default: 0};
    logic [3:0] post_div_value [5] = '{4'h7, 4'h2, 4'hD, 4'h3, 4'h1};
    logic [11:0] apll_int [3] = '{default: 12'h010};
    logic [39:0] apll_num [3] = '{default: 0}, dlf_num [3] = '{default: 0};
    logic [23:0] apll_den [3] = '{default: 0};
    logic dpll_mode [3] = '{default: 0}, dpll_ref_sel [3] = '{default: 0};
    logic apll_locked [3] = '{default: 0}, apll_den_fixed [3];
    logic analog_loop_enable_bit [3];
    logic reference_feedback_value_select [3][2] = '{default: 0};
    logic [32:0] dpll_fb_int [3][2] = '{default: 1};
    logic [39:0] dpll_fb_num [3][2] = '{default: 0};
    logic [39:0] dpll_fb_den [3][2] = '{default: 0};
    pll_chain_pkg::chan_src_e chan_src_sel [16] =
        '{default: pll_chain_pkg::SRC_OFF};
    logic [11:0] output_channel_divider [16] = '{default: 1};
    logic [19:0] sysref_div [16] = '{default: 0};
    logic sysref_en [16] = '{default: 0}, mute_until_lock [16] = '{default: 0};
    logic clock_output_channel [16], post_div_tick [5], pd_ref_tick [3];
    logic fb_clk_tick [3], tdc_valid [3], cal_busy [3], cal_done [3];
    logic [12:0] apll_n_word [3];
    logic [15:0] tdc_err [3];
    int n_fail = 0, n_tests = 0, d;
    pll_divider_chain_control u_dut (.*);
    host_model u_host (.core_clk(core_clk),
        .analog_loop_enable_bit(analog_loop_enable_bit),
        .apll_den_fixed(apll_den_fixed));
    always #20 core_clk = ~core_clk;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask: check
    // spacing between two pulses of post (0), channel (1), phase detector
    // reference (2) or feedback (3) ticks, zero when none come
    task automatic gap(input int ch, input int k, output int g);
        int t;
        logic s;
        g = 0;
        t = 0;
        for (int i = 1; i < 300 && g == 0; i++) begin
            @(negedge core_clk);
            s = ch == 0 ? post_div_tick[k] : ch == 1 ?
                clock_output_channel[k] : ch == 2 ? pd_ref_tick[k] :
                fb_clk_tick[k];
            if (s === 1) begin
                if (t > 0) g = i - t;
                t = i;
            end
        end
    endtask: gap
    task automatic sc_posts;
        for (int k = 0; k < 5; k++) begin
            gap(0, k, d);
            check("post_gap", d, post_div_value[k]);
        end
    endtask: sc_posts
    task automatic sc_routes;
        gap(1, 4, d);
        check("chan4_gap", d, 39);
        gap(1, 6, d);
        check("chan6_gap", d, 3);
        gap(1, 2, d);
        check("chan2_gap", d, 0);
        gap(1, 5, d);
        check("chan5_muted", d, 0);
    endtask: sc_routes
    task automatic sc_lock;
        check("busy_xo_lost", cal_busy[1], 1);
        check("done_xo_lost", cal_done[1], 0);
        xo_loss = 0;
        apll_locked = '{default: 1};
        for (int i = 0; i < 60 && cal_done[1] !== 1; i++) @(negedge core_clk);
        check("cal_done", cal_done[1], 1);
        if (cal_done[1] !== 1) report_and_stop();
        gap(1, 5, d);
        check("chan5_gap", d, 26);
    endtask: sc_lock
    task automatic sc_recal;
        u_host.recal(1);
        @(negedge core_clk);
        check("recal_busy", cal_busy[1], 1);
        check("recal_done", cal_done[1], 0);
        // soft reset pulls the finished loop 0 back into calibration
        soft_rst = 1;
        @(negedge core_clk);
        soft_rst = 0;
        check("soft_rst_busy", cal_busy[0], 1);
        check("soft_rst_done", cal_done[0], 0);
    endtask: sc_recal
    task automatic sc_ref;
        xo_fall_tick = 1;
        xo_r_div[0] = 5'h02;
        gap(2, 0, d);
        check("pd_no_doubler", d, 0);
        xo_doubler_en = 1;
        gap(2, 0, d);
        check("pd_gap", d, 3);
        // half fraction: int and int plus one alternate per pd tick
        apll_num[0] = 40'h80_0000_0000;
        repeat (9) @(negedge core_clk);
        d = apll_n_word[0];
        repeat (3) @(negedge core_clk);
        check("n_word_pair", d + apll_n_word[0], 33);
        dpll_mode[0] = 1;
        repeat (6) @(negedge core_clk);
        check("n_word_loop", apll_n_word[0], 16);
    endtask: sc_ref
    task automatic sc_tdc;
        int i;
        reference_feedback_value_select[0][0] = 1'b1;
        dpll_fb_int[0][1] = 33'h5;
        gap(3, 0, d);
        check("fb_gap", d, 5);
        for (i = 0; i < 9 && fb_clk_tick[0] !== 1; i++) @(negedge core_clk);
        ref_in_tick[0] = 1;
        @(negedge core_clk);
        ref_in_tick[0] = 0;
        for (i = 0; i < 12 && tdc_valid[0] !== 1; i++) @(negedge core_clk);
        check("tdc_valid", tdc_valid[0], 1);
        // feedback period less the reference divider's one cycle
        check("tdc_err", tdc_err[0], 4);
    endtask: sc_tdc
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask: report_and_stop
    initial begin
        chan_src_sel[4] = pll_chain_pkg::SRC_A2_PRI;
        chan_src_sel[5] = pll_chain_pkg::SRC_A2_PRI;
        chan_src_sel[6] = pll_chain_pkg::SRC_A2_SEC;
        chan_src_sel[2] = pll_chain_pkg::SRC_A3;
        output_channel_divider[4] = 12'h003;
        output_channel_divider[5] = 12'h002;
        mute_until_lock[5] = 1;
        repeat (6) @(negedge core_clk);
        sys_rst = 0;
        sc_posts();
        sc_routes();
        sc_lock();
        sc_recal();
        sc_ref();
        sc_tdc();
        report_and_stop();
    end
endmodule: pll_divider_chain_control_bench
